//--- hw/pbu_pkg.sv
// shared constants for the upper port pin logic
package pbu_pkg;
  localparam int unsigned PBU_NPINS = 4;
  localparam int unsigned PBU_AW = 8;
  // register byte addresses
  localparam logic [7:0] PBU_OFF_PORT = 8'h00;
  localparam logic [7:0] PBU_OFF_LAT = 8'h04;
  localparam logic [7:0] PBU_OFF_DIR = 8'h08;
  localparam logic [7:0] PBU_OFF_ICM = 8'h0c;
  localparam logic [7:0] PBU_OFF_IC2 = 8'h10;
  localparam logic [7:0] PBU_OFF_IC3 = 8'h14;
  localparam logic [7:0] PBU_OFF_ANA = 8'h18;
  localparam logic [7:0] PBU_OFF_IST = 8'h1c;
  localparam logic [7:0] PBU_OFF_IMSK = 8'h20;
  // field positions
  localparam int unsigned PBU_FLAG_BIT = 0;
  localparam int unsigned PBU_EN_BIT = 3;
  localparam int unsigned PBU_PRIO_BIT = 0;
  localparam int unsigned PBU_PUD_BIT = 7;
  localparam int unsigned PBU_ANA_BIT = 0;
  // upper pin indices within the group of four
  localparam int unsigned PBU_IDX_ANA = 0;
  localparam int unsigned PBU_IDX_SDI = 1;
  localparam int unsigned PBU_IDX_PCLK = 2;
  localparam int unsigned PBU_IDX_PDAT = 3;
  // reset values
  localparam logic [7:0] PBU_RST_LAT = 8'h00;
  localparam logic [7:0] PBU_RST_DIR = 8'hff;
  localparam logic [7:0] PBU_RST_ICM = 8'h00;
  localparam logic [7:0] PBU_RST_IC2 = 8'h80;
  localparam logic [7:0] PBU_RST_IC3 = 8'h00;
  localparam logic [7:0] PBU_RST_ANA = 8'h00;
  localparam logic [3:0] PBU_RST_IST = 4'h0;
  localparam logic [3:0] PBU_RST_IMSK = 4'h0;
endpackage

//--- hw/pbu_pin_cell.sv
// one upper port pin: output mux, enables, pull-up and digital input gating
module pbu_pin_cell #(
  parameter bit ANALOG_CAP = 1'b0,
  parameter bit PROG_CLK = 1'b0,
  parameter bit PROG_DAT = 1'b0
) (
  input wire logic dir, // 1 input, 0 output
  input wire logic latch, // output latch bit
  input wire logic pud_n, // global pull-up disable
  input wire logic analog, // analog select
  input wire logic prog_en, // programming interface active
  input wire logic prog_drv, // programming data to drive
  input wire logic prog_oe, // programming data enable
  input wire logic remap_sel, // remapped peripheral owns output
  input wire logic remap_val, // remapped peripheral value
  input wire logic pad_in, // pad level
  output logic pad_out, // pad drive value
  output logic pad_oe, // pad drive enable
  output logic pullup_en, // weak pull-up enable
  output logic dig_in // gated digital input
);
  wire prog_own = prog_en & (PROG_CLK | PROG_DAT); // R5
  wire ana_on = ANALOG_CAP & analog; // R3
  wire norm_out = remap_sel ? remap_val : latch; // R8
  assign pad_oe = prog_own ? (PROG_DAT & prog_oe) : ~dir; // R1
  assign pad_out = prog_own ? prog_drv : norm_out; // R7
  assign pullup_en = ~prog_own & dir & ~pud_n & ~ana_on; // R2
  assign dig_in = (prog_own | ana_on) ? 1'b0 : pad_in; // R3
endmodule

//--- hw/pbu_change_det.sv
// compares input pins with the value latched at the last port access
module pbu_change_det #(
  parameter int unsigned N = 4
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic [N-1:0] pins, // digital pin levels
  input wire logic [N-1:0] dir, // 1 = input
  input wire logic capture, // port accessed
  output logic [N-1:0] miss, // per-pin mismatch
  output logic any_miss // ored mismatch
);
  logic [N-1:0] last_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= '0;
    end else if (capture) begin
      last_reg <= pins;
    end
  end
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_cmp
      assign miss[i] = dir[i] & (pins[i] ^ last_reg[i]); // R10
    end
  endgenerate
  assign any_miss = |miss;
  property p_out_excluded;
    @(posedge pclk) disable iff (!presetn)
      (dir == '0) |-> !any_miss;
  endproperty
  a_out_excluded: assert property (p_out_excluded) else $error("output pin counted as change"); // R10
  property p_capture_clears;
    @(posedge pclk) disable iff (!presetn)
      (capture && $stable(pins)) |=> (miss == '0 || !$stable(pins));
  endproperty
  a_capture_clears: assert property (p_capture_clears) else $error("mismatch after port access"); // R10
endmodule

//--- hw/pbu_port_upper.sv
// upper half port pin logic with apb registers and change interrupt
// Operation
// R1: output pin driven from latch, analog ignored
// R2: input reads port; pull-up when not disabled
// R3: analog pin4 drops digital input and pull-up
// R4: reset analog default follows configuration strap
// R5: programming mode overrides shared clock, data pins
// R6: pin6 takes programming clock, direction ignored
// R7: pin7 is bidirectional programming data line
// R8: pins serve remappable peripherals, direction selects
// R9: pin5 feeds serial data input when input
// R10: input pins compared with last latched value
// R11: ored mismatch sets flag, held while persisting
// R12: software accesses port, waits, then clears
// R13: port change can wake from sleep, idle
// R14: request needs flag and enable, prioritised
//
// The APB register port and the register addresses were decided locally.
module pbu_port_upper
  import pbu_pkg::*;
#(
  parameter int unsigned NPINS = pbu_pkg::PBU_NPINS
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [pbu_pkg::PBU_AW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [3:0] pin_in, // pad levels, pins 4..7
  output logic [3:0] pin_out, // pad drive values
  output logic [3:0] pin_oe, // pad drive enables
  output logic [3:0] pin_pullup_en, // weak pull-up enables
  output logic pin4_analog_en, // pin4 routed to converter
  input wire logic por_analog_default, // configuration strap
  input wire logic prog_enable, // programming or debug active
  output logic prog_serial_clock, // clock from pin6
  output logic prog_serial_data_in, // data from pin7
  input wire logic prog_serial_data_out, // data to pin7
  input wire logic prog_serial_data_oe, // pin7 drive enable
  input wire logic [3:0] remap_out_sel, // remap output owns pin
  input wire logic [3:0] remap_out_val, // remap output value
  output logic [3:0] remap_in, // remap input levels
  output logic serial_periph_data_in, // serial data input
  output logic port_change_irq_high, // high priority request
  output logic port_change_irq_low, // low priority request
  output logic wake_req, // wake from sleep or idle
  output logic irq // masked status interrupt
);
  import pbu_pkg::*;

  generate
    if (NPINS != 4) begin : g_bad
      $error("pbu_port_upper serves exactly four pins");
    end
  endgenerate

  logic [7:0] lat_reg;
  logic [7:0] dir_reg;
  logic [7:0] icm_reg;
  logic [7:0] ic2_reg;
  logic [7:0] ic3_reg;
  logic [7:0] ana_reg;
  logic [3:0] ist_reg;
  logic [3:0] imsk_reg;
  logic [31:0] prdata_reg;
  logic strap_done_reg;
  logic [3:0] miss_prev_reg;
  logic [3:0] ist_next;
  logic [7:0] icm_next;

  // bus decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_port = (paddr == PBU_OFF_PORT);
  wire hit_lat = (paddr == PBU_OFF_LAT);
  wire hit_dir = (paddr == PBU_OFF_DIR);
  wire hit_icm = (paddr == PBU_OFF_ICM);
  wire hit_ic2 = (paddr == PBU_OFF_IC2);
  wire hit_ic3 = (paddr == PBU_OFF_IC3);
  wire hit_ana = (paddr == PBU_OFF_ANA);
  wire hit_ist = (paddr == PBU_OFF_IST);
  wire hit_imsk = (paddr == PBU_OFF_IMSK);
  wire mapped = hit_port | hit_lat | hit_dir | hit_icm | hit_ic2 |
                hit_ic3 | hit_ana | hit_ist | hit_imsk;
  wire [7:0] wb = pwdata[7:0];

  // control fields
  wire [3:0] dir_up = dir_reg[7:4];
  wire [3:0] lat_up = lat_reg[7:4];
  wire pud_n = ic2_reg[PBU_PUD_BIT];
  wire chg_prio = ic2_reg[PBU_PRIO_BIT];
  wire chg_en = icm_reg[PBU_EN_BIT];
  wire chg_flag = icm_reg[PBU_FLAG_BIT];
  wire ana_sel = ana_reg[PBU_ANA_BIT];

  // pin cells
  logic [3:0] dig_in;
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pin
      pbu_pin_cell #(
        .ANALOG_CAP(i == PBU_IDX_ANA),
        .PROG_CLK(i == PBU_IDX_PCLK),
        .PROG_DAT(i == PBU_IDX_PDAT)
      ) u_cell (
        .dir(dir_up[i]),
        .latch(lat_up[i]),
        .pud_n(pud_n),
        .analog(ana_sel),
        .prog_en(prog_enable),
        .prog_drv(prog_serial_data_out),
        .prog_oe(prog_serial_data_oe),
        .remap_sel(remap_out_sel[i]),
        .remap_val(remap_out_val[i]),
        .pad_in(pin_in[i]),
        .pad_out(pin_out[i]),
        .pad_oe(pin_oe[i]),
        .pullup_en(pin_pullup_en[i]),
        .dig_in(dig_in[i])
      );
    end
  endgenerate

  assign pin4_analog_en = ana_sel; // R3
  // programming pins taken regardless of direction
  assign prog_serial_clock = prog_enable & pin_in[PBU_IDX_PCLK]; // R6
  assign prog_serial_data_in = prog_enable & pin_in[PBU_IDX_PDAT]; // R7
  assign remap_in = dig_in & dir_up; // R8
  assign serial_periph_data_in = dig_in[PBU_IDX_SDI] & dir_up[PBU_IDX_SDI]; // R9

  // change detection
  logic [3:0] miss;
  logic any_miss;
  wire port_touch = access & hit_port;
  pbu_change_det #(
    .N(4)
  ) u_chg (
    .pclk(pclk),
    .presetn(presetn),
    .pins(dig_in),
    .dir(dir_up),
    .capture(port_touch),
    .miss(miss),
    .any_miss(any_miss)
  );

  // flag set by mismatch wins over a software clear
  always_comb begin
    icm_next = icm_reg;
    if (wr && hit_icm) begin
      icm_next = {wb[7:1], chg_flag & wb[PBU_FLAG_BIT]};
    end
    icm_next[PBU_FLAG_BIT] = icm_next[PBU_FLAG_BIT] | any_miss; // R11
  end

  // sticky status: onset of each pin mismatch, cleared by writing one
  wire [3:0] miss_rise = miss & ~miss_prev_reg;
  always_comb begin
    ist_next = ist_reg;
    if (wr && hit_ist) begin
      ist_next = ist_reg & ~wb[3:0];
    end
    ist_next = ist_next | miss_rise;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icm_reg <= PBU_RST_ICM;
      ist_reg <= PBU_RST_IST;
      miss_prev_reg <= 4'h0;
    end else begin
      icm_reg <= icm_next;
      ist_reg <= ist_next;
      miss_prev_reg <= miss;
    end
  end

  // port writes land in the output latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_reg <= PBU_RST_LAT;
    end else if (wr && (hit_port || hit_lat)) begin
      lat_reg <= wb; // R1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= PBU_RST_DIR;
      ic2_reg <= PBU_RST_IC2;
      ic3_reg <= PBU_RST_IC3;
      imsk_reg <= PBU_RST_IMSK;
    end else if (wr) begin
      if (hit_dir) dir_reg <= wb;
      if (hit_ic2) ic2_reg <= wb;
      if (hit_ic3) ic3_reg <= wb;
      if (hit_imsk) imsk_reg <= wb[3:0];
    end
  end

  // analog select loads the strap on the first edge after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ana_reg <= PBU_RST_ANA;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      ana_reg[PBU_ANA_BIT] <= por_analog_default; // R4
      strap_done_reg <= 1'b1;
    end else if (wr && hit_ana) begin
      ana_reg <= wb;
    end
  end

  // read data registered in the setup phase
  wire [7:0] port_rd = {dig_in, 4'h0}; // R2
  wire [7:0] rd_mux =
    hit_port ? port_rd :
    hit_lat ? lat_reg :
    hit_dir ? dir_reg :
    hit_icm ? icm_reg :
    hit_ic2 ? ic2_reg :
    hit_ic3 ? ic3_reg :
    hit_ana ? ana_reg :
    hit_ist ? {4'h0, ist_reg} :
    hit_imsk ? {4'h0, imsk_reg} : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_reg <= {24'h00_0000, rd_mux};
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // change request routing
  wire chg_req = chg_flag & chg_en;
  assign port_change_irq_high = chg_req & chg_prio; // R14
  assign port_change_irq_low = chg_req & ~chg_prio; // R14
  assign wake_req = chg_req; // R13
  assign irq = |(ist_reg & imsk_reg);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_out_drive;
    (!prog_enable && !dir_up[0] && !remap_out_sel[0])
      |-> (pin_oe[0] && pin_out[0] == lat_up[0]);
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("output pin not driven from latch"); // R1

  property p_pullup;
    pin_pullup_en[1] |-> (dir_up[1] && !pud_n);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on while not allowed"); // R2

  property p_in_read;
    (setup && !pwrite && hit_port && !prog_enable)
      |=> prdata[5] == $past(pin_in[1]);
  endproperty
  a_in_read: assert property (p_in_read) else $error("port read lost pin level"); // R2

  property p_analog;
    ana_sel |-> (!pin_pullup_en[0] && !dig_in[0]);
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin4 digital path active"); // R3

  property p_strap;
    $rose(strap_done_reg) |-> ana_sel == $past(por_analog_default);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not loaded at reset"); // R4

  property p_prog_own;
    prog_enable |-> (!pin_oe[2] && pin_oe[3] == prog_serial_data_oe
      && !pin_pullup_en[2] && !pin_pullup_en[3]);
  endproperty
  a_prog_own: assert property (p_prog_own) else $error("programming pins not owned"); // R5

  property p_prog_clk;
    prog_enable |-> prog_serial_clock == pin_in[2];
  endproperty
  a_prog_clk: assert property (p_prog_clk) else $error("programming clock not passed"); // R6

  property p_prog_dat;
    (prog_enable && prog_serial_data_oe)
      |-> (pin_out[3] == prog_serial_data_out && prog_serial_data_in == pin_in[3]);
  endproperty
  a_prog_dat: assert property (p_prog_dat) else $error("programming data path wrong"); // R7

  property p_remap;
    (!prog_enable && remap_out_sel[1] && !dir_up[1]) |-> pin_out[1] == remap_out_val[1];
  endproperty
  a_remap: assert property (p_remap) else $error("remap output not on pin"); // R8

  property p_sdi;
    (dir_up[1]) |-> serial_periph_data_in == pin_in[1];
  endproperty
  a_sdi: assert property (p_sdi) else $error("serial data input wrong"); // R9

  sequence s_miss;
    any_miss;
  endsequence
  sequence s_flag_held;
    chg_flag [*2];
  endsequence
  property p_flag;
    s_miss ##1 any_miss |-> s_flag_held;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not held during mismatch"); // R11

  property p_flag_set;
    any_miss |=> chg_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("mismatch did not set flag"); // R11

  property p_req;
    (port_change_irq_high || port_change_irq_low) == (chg_flag && chg_en)
      && !(port_change_irq_high && port_change_irq_low);
  endproperty
  a_req: assert property (p_req) else $error("change request gating wrong"); // R14

  property p_wake;
    (chg_flag && chg_en) |-> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("change did not request wake"); // R13

  property p_port_write;
    (wr && hit_port) |=> lat_reg == $past(wb);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port write missed the latch"); // R1

  property p_set_wins;
    (wr && hit_icm && !wb[PBU_FLAG_BIT] && any_miss) |=> chg_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag clear beat a mismatch"); // R11

  property p_status_onset;
    (|miss_rise) |=> ((ist_reg & $past(miss_rise)) == $past(miss_rise));
  endproperty
  a_status_onset: assert property (p_status_onset) else $error("status missed a mismatch onset"); // R10
endmodule

//--- dv/pbu_board.sv
// board model for the four upper pads: external drivers, pull-ups, floating lines
module pbu_board (
  input wire logic pclk, // system clock
  input wire logic [3:0] pin_out, // device drive values
  input wire logic [3:0] pin_oe, // device drive enables
  input wire logic [3:0] pin_pullup_en, // device weak pull-ups
  input wire logic [3:0] ext_en, // board drives the pad
  input wire logic [3:0] ext_val, // board drive value
  output logic [3:0] pin_in // resolved pad levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] flt_reg = 4'h0;

  // a pad nobody drives must not hold its last level
  always @(posedge pclk) begin
    flt_reg <= ~pin_in;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = flt_reg[i];
    end
  end
endmodule

//--- dv/pbu_port_upper_test.sv
// self-checking bench for the upper port pin logic
module pbu_port_upper_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pbu_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, errv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pin_in, pin_out, pin_oe, pin_pullup_en, remap_out_sel, remap_out_val, remap_in, ext_en, ext_val;
  logic pin4_analog_en, por_analog_default, prog_enable, prog_serial_clock, prog_serial_data_in;
  logic prog_serial_data_out, prog_serial_data_oe, serial_periph_data_in;
  logic port_change_irq_high, port_change_irq_low, wake_req, irq;
  int error_cnt = 0;
  int check_count = 0;

  pbu_port_upper dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .pin4_analog_en(pin4_analog_en),
    .por_analog_default(por_analog_default), .prog_enable(prog_enable), .prog_serial_clock(prog_serial_clock),
    .prog_serial_data_in(prog_serial_data_in), .prog_serial_data_out(prog_serial_data_out),
    .prog_serial_data_oe(prog_serial_data_oe), .remap_out_sel(remap_out_sel), .remap_out_val(remap_out_val),
    .remap_in(remap_in), .serial_periph_data_in(serial_periph_data_in),
    .port_change_irq_high(port_change_irq_high), .port_change_irq_low(port_change_irq_low),
    .wake_req(wake_req), .irq(irq));

  pbu_board board_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  always #5 pclk = ~pclk;

  task automatic print_verdict();
    if (error_cnt == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %0t got %h expected %h", $time, g, e);
      error_cnt++;
    end
  endtask

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, {24'h0, e});
  endtask

  task automatic pins(input logic [3:0] v);
    @(posedge pclk);
    ext_val <= v;
    repeat (3) @(negedge pclk);
  endtask

  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    por_analog_default = 1'b1; prog_enable = 1'b0; prog_serial_data_out = 1'b0; prog_serial_data_oe = 1'b0;
    remap_out_sel = 4'h0; remap_out_val = 4'h0; ext_en = 4'hf; ext_val = 4'hf;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk(pin4_analog_en, 1'b1);
    chk({pin_oe, pin_pullup_en}, 8'h00);
    rd(PBU_OFF_ANA, 8'h01);
    rd(PBU_OFF_DIR, PBU_RST_DIR);
    rd(PBU_OFF_LAT, PBU_RST_LAT);
    rd(PBU_OFF_IC2, PBU_RST_IC2);
    rd(PBU_OFF_IC3, PBU_RST_IC3);
    wr(PBU_OFF_IC3, 8'h5a);
    rd(PBU_OFF_IC3, 8'h5a);
    wr(PBU_OFF_IC2, 8'h00);
    @(negedge pclk);
    chk(pin_pullup_en, 4'he);
    rd(PBU_OFF_PORT, 8'he0);
    wr(PBU_OFF_LAT, 8'h50);
    wr(PBU_OFF_DIR, 8'h00);
    remap_out_sel <= 4'h2;
    remap_out_val <= 4'h2;
    @(negedge pclk);
    chk({pin_oe, pin_pullup_en, pin_out}, 12'hf07);
    wr(PBU_OFF_ANA, 8'h00);
    remap_out_sel <= 4'h0;
    wr(PBU_OFF_DIR, 8'hff);
    ext_en <= 4'h0;
    rd(PBU_OFF_PORT, 8'hf0);
    ext_en <= 4'hf;
    pins(4'b0010);
    chk({serial_periph_data_in, remap_in}, 5'h12);
    // change detection, priority high, all status bits unmasked
    wr(PBU_OFF_IC2, 8'h01);
    wr(PBU_OFF_IMSK, 8'h0f);
    rd(PBU_OFF_PORT, 8'h20);
    wr(PBU_OFF_ICM, 8'h08);
    wr(PBU_OFF_IST, 8'h0f);
    rd(PBU_OFF_IST, 8'h00);
    chk(irq, 1'b0);
    pins(4'b0000);
    chk({wake_req, port_change_irq_high, port_change_irq_low, irq}, 4'hd);
    rd(PBU_OFF_ICM, 8'h09);
    rd(PBU_OFF_IST, 8'h02);
    wr(PBU_OFF_ICM, 8'h08);
    rd(PBU_OFF_ICM, 8'h09);
    rd(PBU_OFF_PORT, 8'h00);
    wr(PBU_OFF_ICM, 8'h08);
    rd(PBU_OFF_ICM, 8'h08);
    chk({wake_req, irq}, 2'b01);
    wr(PBU_OFF_IST, 8'h02);
    rd(PBU_OFF_IST, 8'h00);
    chk(irq, 1'b0);
    // masked event on pin6, routed at low priority
    wr(PBU_OFF_IMSK, 8'h00);
    wr(PBU_OFF_IC2, 8'h00);
    pins(4'b0100);
    chk({port_change_irq_high, port_change_irq_low, irq}, 3'b010);
    rd(PBU_OFF_IST, 8'h04);
    rd(PBU_OFF_PORT, 8'h40);
    wr(PBU_OFF_ICM, 8'h08);
    wr(PBU_OFF_IST, 8'h04);
    // an output pin changing level must not raise the flag
    wr(PBU_OFF_DIR, 8'hdf);
    wr(PBU_OFF_LAT, 8'h20);
    rd(PBU_OFF_ICM, 8'h08);
    chk(pin_out[1], 1'b1);
    // programming mode takes pins 6 and 7 whatever the direction bits say
    wr(PBU_OFF_DIR, 8'h00);
    wr(PBU_OFF_PORT, 8'h00);
    rd(PBU_OFF_LAT, 8'h00);
    prog_enable <= 1'b1;
    prog_serial_data_oe <= 1'b1;
    prog_serial_data_out <= 1'b1;
    pins(4'b0100);
    chk({prog_serial_clock, pin_oe, pin_out[3]}, 6'h37);
    @(posedge pclk);
    prog_serial_data_oe <= 1'b0;
    pins(4'b1000);
    chk({prog_serial_data_in, prog_serial_clock, pin_oe}, 6'h23);
    // second reset in mid-run with the strap low
    @(posedge pclk);
    prog_enable <= 1'b0;
    por_analog_default <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    chk(pin4_analog_en, 1'b0);
    rd(PBU_OFF_DIR, PBU_RST_DIR);
    rd(PBU_OFF_ANA, 8'h00);
    apb(1'b0, 8'h30, 32'h0);
    chk(errv, 1'b1);
    chk(rdv, 32'h0);
    print_verdict();
  end
endmodule
